// File: tb_top.sv
`timescale 1ns/10ps
`include "wdg_regs.vh"
module tb_top;
  reg         aclk = 1'h0, aresetn = 1'h0, por_event = 1'h1, cpu_sleeping = 1'h0;
  reg  [3:0]  dog_mode_cfg = 4'hF, s_axi_wstrb = 4'hF;
  reg  [9:0]  s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        irq, dog_irq, wake_req, sys_reset_req;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     failures = 0, checks_done = 0, rst_cnt = 0, wake_cnt = 0, w0, i;
  logic [31:0] d;
  logic [1:0] r;
  int         env[3] = '{32'h10, 32'h80, 32'h90};
  wdg_timer #(.OSC_DIV(4)) dut (.aclk, .aresetn, .por_event, .dog_mode_cfg, .cpu_sleeping,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .dog_irq, .wake_req, .sys_reset_req);
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (sys_reset_req === 1'h1) rst_cnt++;
    if (wake_req === 1'h1) wake_cnt++;
  end
  task stop_test;
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {a, 2'h0};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {a, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // control writes need the two-key unlock right before them
  task cw(input [7:0] v);
    wr(`WDG_TA_ADDR, `WDG_TA_KEY1);
    wr(`WDG_TA_ADDR, `WDG_TA_KEY2);
    wr(`WDG_CTRL_ADDR, v);
  endtask
  task rst(input p);
    @(posedge aclk);
    aresetn <= 1'h0;
    por_event <= p;
    cyc(2);
    aresetn <= 1'h1;
    por_event <= 1'h0;
  endtask
  initial begin
    cyc(20000);
    failures++;
    $display("unexpected at %0t: timeout", $time);
    stop_test;
  end
  initial begin
    void'($urandom(15151));
    rst(1'h1);
    rd(8'hC0);
    chk(r, `WDG_RESP_SLVERR);
    rd(`WDG_CTRL_ADDR);
    chk(d, `WDG_CTRL_POR);
    wr(`WDG_CTRL_ADDR, $urandom % 256);
    rd(`WDG_CTRL_ADDR);
    chk(d, `WDG_CTRL_POR);
    // divide by one: 64 ticks of 4 cycles
    cw(8'h80);
    rd(`WDG_CTRL_ADDR);
    chk(d, 8'h80);
    cyc(220);
    rd(`WDG_IRQ_STAT_ADDR);
    chk(d[0], 1'h0);
    cyc(60);
    rd(`WDG_CTRL_ADDR);
    chk(d, 8'hA0);
    wr(`WDG_IRQ_MASK_ADDR, 32'h1);
    cyc(2);
    chk(irq, 1'h1);
    wr(`WDG_IRQ_STAT_ADDR, 32'h1);
    cyc(2);
    chk(irq, 1'h0);
    cyc(240);
    chk(irq, 1'h1);
    for (i = 0; i < 3; i++) begin
      wr(`WDG_ENV_ADDR, env[i]);
      cyc(2);
      chk(dog_irq, env[i] == 32'h90);
    end
    wr(`WDG_IRQ_MASK_ADDR, 32'h0);
    cyc(2);
    chk(irq, 1'h0);
    cw(8'hE0);
    rd(`WDG_CTRL_ADDR);
    chk(d, 8'h80);
    wr(`WDG_IRQ_STAT_ADDR, 32'h1);
    cyc(220);
    rd(`WDG_IRQ_STAT_ADDR);
    chk(d[0], 1'h0);
    cyc(60);
    rd(`WDG_IRQ_STAT_ADDR);
    chk(d[0], 1'h1);
    cpu_sleeping <= 1'h1;
    w0 = wake_cnt;
    cyc(600);
    chk(wake_cnt, w0);
    cw(8'h90);
    cyc(300);
    chk(wake_cnt, w0 + 1);
    cpu_sleeping <= 1'h0;
    // reset timer: runs at once, fed once, then left to starve
    dog_mode_cfg <= $urandom % 5;
    rst(1'h0);
    rd(`WDG_CTRL_ADDR);
    chk(d, 8'h00);
    cyc(380);
    cw(8'hC0);
    rd(`WDG_CTRL_ADDR);
    chk(d[7], 1'h0);
    cyc(2000);
    chk(rst_cnt, 0);
    cyc(500);
    chk(rst_cnt, 1);
    rd(`WDG_CTRL_ADDR);
    chk(d[3], 1'h1);
    rst(1'h0);
    rd(`WDG_CTRL_ADDR);
    chk(d & 32'h0F, 8'h08);
    rst(1'h1);
    rd(`WDG_CTRL_ADDR);
    chk(d, `WDG_CTRL_POR);
    // stop-in-sleep reset timer: fastest prescale, no wake while asleep
    dog_mode_cfg <= `WDG_MODE_STOP_IDLE;
    cw(8'h00);
    cpu_sleeping <= 1'h1;
    w0 = wake_cnt;
    cyc(300);
    chk(wake_cnt, w0);
    stop_test;
  end
endmodule // tb_top

// File: wdg_assertions.sv
`timescale 1ns/10ps
`include "wdg_regs.vh"
module wdg_assertions (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // chip state
  input wire [3:0]  dog_mode_cfg,
  input wire        cpu_sleeping,
  // bus
  input wire [9:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire [9:0]  s_axi_araddr,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // outputs
  input wire        dog_irq,
  input wire        wake_req,
  input wire        sys_reset_req
);
  reg [9:0] wa;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  function automatic bit hit(input [9:0] a);
    hit = a[9:2] == `WDG_CTRL_ADDR || a[9:2] == `WDG_IRQ_STAT_ADDR
       || a[9:2] == `WDG_IRQ_MASK_ADDR || a[9:2] == `WDG_ENV_ADDR
       || a[9:2] == `WDG_TA_ADDR;
  endfunction
  always @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
  end
  property p_rd_resp;
    $rose(s_axi_rvalid) |->
      s_axi_rresp == (hit($past(s_axi_araddr)) ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR);
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response code wrong");
  property p_rd_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits not zero");
  property p_wr_resp;
    $rose(s_axi_bvalid) |-> s_axi_bresp == (hit(wa) ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response code wrong");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_gp_norst;
    dog_mode_cfg == `WDG_MODE_GP && $past(dog_mode_cfg) == `WDG_MODE_GP |-> !sys_reset_req;
  endproperty
  a_gp_norst: assert property (p_gp_norst) else $error("reset in timer mode");
  property p_rst_pulse;
    sys_reset_req |=> !sys_reset_req [*8];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  property p_wake_cause;
    wake_req |-> $past(cpu_sleeping);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake while awake");
  property p_wake_pulse;
    wake_req |=> !wake_req;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  c_rst: cover property (sys_reset_req);
  c_wake: cover property (wake_req);
  c_dirq: cover property (dog_irq);
endmodule // wdg_assertions
bind wdg_timer wdg_assertions u_chk (.aclk, .aresetn, .dog_mode_cfg, .cpu_sleeping,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .dog_irq, .wake_req, .sys_reset_req);

// File: wdg_prescaler.v
`timescale 1ns/10ps
`include "wdg_regs.vh"
// prescales the oscillator tick: codes 0..7 -> 1,4,8,...,256
module wdg_prescaler (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // control
  input  wire       tick_in,
  input  wire       enable,
  input  wire       clear,
  input  wire [2:0] sel,
  // output
  output reg        tick_out
);
  reg  [7:0] count;
  wire [7:0] limit;

  // code 0 divides by one, others by 2^(code+1)
  assign limit = (sel == 3'h0) ? 8'h00 : ((8'h02 << sel) - 8'h01);

  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (enable && tick_in) begin
        if (count >= limit) begin
          count    <= 8'h00;
          tick_out <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule // wdg_prescaler

// File: wdg_regs.vh
`ifndef WDG_REGS_VH
`define WDG_REGS_VH
// register indices; the bus byte address is four times the index
`define WDG_CTRL_ADDR      8'hAA
`define WDG_IRQ_STAT_ADDR  8'hB0
`define WDG_IRQ_MASK_ADDR  8'hB4
`define WDG_ENV_ADDR       8'hB8
`define WDG_TA_ADDR        8'hBC
// control field positions
`define WDG_RUN_BIT        7
`define WDG_CLR_BIT        6
`define WDG_TOF_BIT        5
`define WDG_SLEEP_BIT      4
`define WDG_RSTF_BIT       3
`define WDG_PS_MSB         2
// reset values
`define WDG_CTRL_POR       8'h07
`define WDG_MODE_GP        4'hF
`define WDG_MODE_STOP_IDLE 4'h5
// timed access unlock bytes
`define WDG_TA_KEY1        8'hAA
`define WDG_TA_KEY2        8'h55
`define WDG_TA_WINDOW      4'h4
// timing
`define WDG_INTERVAL_TICKS 64
`define WDG_GRACE_TICKS    512
`define WDG_OSC_HZ         10000
`define WDG_CLK_HZ         50000000
`define WDG_OSC_DIV        (`WDG_CLK_HZ / `WDG_OSC_HZ)
// bus response codes
`define WDG_RESP_OKAY      2'h0
`define WDG_RESP_SLVERR    2'h2
`endif

// File: wdg_timer.v
`timescale 1ns/10ps
`include "wdg_regs.vh"
// Overview of operation
// - Mode field all ones makes a general-purpose timer; run and sleep-run bits writable.
// - In general-purpose mode the run bit starts and halts counting.
// - Completing the selected interval sets the time-out flag.
// - After a general-purpose time-out the counter keeps counting.
// - dog_irq only when the dog enable and global enable are both set; irq follows the masked status.
// - Counter ticks from the low-speed 10 kHz oscillator.
// - With sleep-run set, counting continues in power-down and wakes the core.
// - Sleep-run bit acts only in general-purpose mode; 0 stops in sleep.
// - Writing one to clear zeroes the counter; reads one while still pending.
// - Time-out flag is sticky; software clears it by writing one.
// - Reset flag set by a dog reset, cleared by power-on or by a control write of zero.
// - Control register at AAH, writes only through timed access, resets to 07h at power-on.
// - Mode 1111 general timer, 0101 reset timer stopping in sleep, else running.
// - Reset timer: no clear within 512 oscillator clocks after time-out resets.
// - Interval is 64 prescaled oscillator periods.
// - In reset-timer mode run bits are ignored; counting starts at once.
module wdg_timer #(
  parameter OSC_DIV = `WDG_OSC_DIV
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        por_event,
  // chip state
  input  wire [3:0]  dog_mode_cfg,
  input  wire        cpu_sleeping,
  // axi4-lite write address
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // outputs
  output reg         irq,
  output reg         dog_irq,
  output reg         wake_req,
  output reg         sys_reset_req
);
  // control fields
  reg        dog_run;
  reg        dog_run_in_sleep;
  reg        dog_timeout_flag;
  reg        dog_reset_flag;
  reg [2:0]  dog_prescale_sel;
  reg        clr_pending;
  // environment
  reg        dog_irq_enable;
  reg        global_irq_enable;
  reg [1:0]  irq_stat;
  reg [1:0]  irq_mask;
  // timed access
  reg [1:0]  ta_state;
  reg [3:0]  ta_window;
  // oscillator and counters
  reg [15:0] osc_cnt;
  reg        osc_tick;
  reg [5:0]  dog_count;
  reg [9:0]  grace_cnt;
  reg        grace_active;
  reg        dog_reset_seen;
  // bus holding
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire        pre_tick;
  wire        mode_gp;
  wire        counting;
  wire        ta_open;
  wire        wr_fire;
  wire        ctrl_wr;
  wire        timeout;
  wire [7:0]  ctrl_val;
  wire        clr_req;
  wire [1:0]  irq_events;
  reg  [31:0] rd_val;
  reg  [1:0]  rd_resp;

  localparam [9:0] GRACE_LAST = `WDG_GRACE_TICKS - 1;
  localparam [7:0] CTRL_POR   = `WDG_CTRL_POR;

  assign mode_gp = (dog_mode_cfg == `WDG_MODE_GP);
  // reset timer runs from start; gp needs run bit; sleep handling per mode
  assign counting = mode_gp ? (dog_run && (!cpu_sleeping || dog_run_in_sleep))
                            : (!cpu_sleeping || (dog_mode_cfg != `WDG_MODE_STOP_IDLE));
  assign ta_open  = (ta_state == 2'h2);
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign ctrl_wr  = wr_fire && (aw_addr == `WDG_CTRL_ADDR) && w_strb[0] && ta_open;
  assign clr_req  = ctrl_wr && w_data[`WDG_CLR_BIT];
  assign timeout  = pre_tick && (dog_count == 6'h3F);
  assign ctrl_val = {dog_run, clr_pending, dog_timeout_flag, dog_run_in_sleep,
                     dog_reset_flag, dog_prescale_sel};
  assign irq_events = {sys_reset_req, timeout};

  // oscillator tick derived from system clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt  <= 16'h0000;
      osc_tick <= 1'b0;
    end else if (osc_cnt == OSC_DIV[15:0] - 16'h0001) begin
      osc_cnt  <= 16'h0000;
      osc_tick <= 1'b1;
    end else begin
      osc_cnt  <= osc_cnt + 16'h0001;
      osc_tick <= 1'b0;
    end
  end

  wdg_prescaler u_pre (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (osc_tick),
    .enable   (counting),
    .clear    (clr_pending),
    .sel      (dog_prescale_sel),
    .tick_out (pre_tick)
  );

  // interval counter; wraps and keeps going after a time-out
  always @(posedge aclk) begin
    if (!aresetn || clr_pending) begin
      dog_count <= 6'h00;
    end else if (pre_tick) begin
      dog_count <= dog_count + 6'h01;
    end
  end

  // clear takes effect one cycle later, so the bit reads back one meanwhile
  always @(posedge aclk) begin
    if (!aresetn) begin
      clr_pending <= 1'b0;
    end else begin
      clr_pending <= clr_req;
    end
  end

  // grace window before a reset in reset-timer mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      grace_active  <= 1'b0;
      grace_cnt     <= 10'h000;
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= 1'b0;
      if (clr_req) begin
        grace_active <= 1'b0;
      end else if (timeout && !mode_gp && !grace_active) begin
        grace_active <= 1'b1;
        grace_cnt    <= 10'h000;
      end else if (grace_active && osc_tick) begin
        if (grace_cnt == GRACE_LAST) begin
          grace_active  <= 1'b0;
          sys_reset_req <= 1'b1;
        end else begin
          grace_cnt <= grace_cnt + 10'h001;
        end
      end
    end
  end

  // reset seen survives aresetn; it follows sys_reset_req a cycle later, power-on clears it
  always @(posedge aclk) begin
    if (por_event) begin
      dog_reset_seen <= 1'b0;
    end else begin
      dog_reset_seen <= sys_reset_req;
    end
  end

  // fields with power-on-only reset behaviour
  always @(posedge aclk) begin
    if (por_event) begin
      dog_reset_flag   <= 1'b0;
      dog_prescale_sel <= CTRL_POR[`WDG_PS_MSB:0];
    end else if (dog_reset_seen) begin
      dog_reset_flag <= 1'b1;
    end else if (ctrl_wr) begin
      dog_reset_flag   <= w_data[`WDG_RSTF_BIT];
      dog_prescale_sel <= w_data[`WDG_PS_MSB:0];
    end
  end

  // ordinary control fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      dog_run          <= 1'b0;
      dog_run_in_sleep <= 1'b0;
      dog_timeout_flag <= 1'b0;
    end else begin
      if (ctrl_wr && mode_gp) begin
        dog_run          <= w_data[`WDG_RUN_BIT];
        dog_run_in_sleep <= w_data[`WDG_SLEEP_BIT];
      end
      // set wins over a simultaneous software clear
      if (timeout) begin
        dog_timeout_flag <= 1'b1;
      end else if (ctrl_wr && w_data[`WDG_TOF_BIT]) begin
        dog_timeout_flag <= 1'b0;
      end
    end
  end

  // timed access: two keys, then a short window for one write
  always @(posedge aclk) begin
    if (!aresetn) begin
      ta_state  <= 2'h0;
      ta_window <= 4'h0;
    end else if (wr_fire && aw_addr == `WDG_TA_ADDR && w_strb[0]) begin
      if (w_data[7:0] == `WDG_TA_KEY1) begin
        ta_state <= 2'h1;
      end else if (ta_state == 2'h1 && w_data[7:0] == `WDG_TA_KEY2) begin
        ta_state  <= 2'h2;
        ta_window <= `WDG_TA_WINDOW;
      end else begin
        ta_state <= 2'h0;
      end
    end else if (ctrl_wr) begin
      ta_state <= 2'h0;
    end else if (ta_state == 2'h2) begin
      if (ta_window == 4'h0) begin
        ta_state <= 2'h0;
      end else begin
        ta_window <= ta_window - 4'h1;
      end
    end
  end

  // environment, sticky status and mask
  always @(posedge aclk) begin
    if (!aresetn) begin
      dog_irq_enable    <= 1'b0;
      global_irq_enable <= 1'b0;
      irq_stat          <= 2'h0;
      irq_mask          <= 2'h0;
    end else begin
      if (wr_fire && aw_addr == `WDG_ENV_ADDR && w_strb[0]) begin
        dog_irq_enable    <= w_data[4];
        global_irq_enable <= w_data[7];
      end
      if (wr_fire && aw_addr == `WDG_IRQ_MASK_ADDR && w_strb[0]) begin
        irq_mask <= w_data[1:0];
      end
      if (wr_fire && aw_addr == `WDG_IRQ_STAT_ADDR && w_strb[0]) begin
        irq_stat <= (irq_stat & ~w_data[1:0]) | irq_events;
      end else begin
        irq_stat <= irq_stat | irq_events;
      end
    end
  end

  // registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq      <= 1'b0;
      dog_irq  <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq      <= |(irq_stat & irq_mask);
      dog_irq  <= dog_timeout_flag && dog_irq_enable && global_irq_enable;
      // wake only when counting carried on through sleep
      wake_req <= timeout && cpu_sleeping;
    end
  end

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDG_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !w_held && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `WDG_CTRL_ADDR, `WDG_IRQ_STAT_ADDR, `WDG_IRQ_MASK_ADDR,
          `WDG_ENV_ADDR, `WDG_TA_ADDR: s_axi_bresp <= `WDG_RESP_OKAY;
          default: s_axi_bresp <= `WDG_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // read decode
  always @* begin
    rd_val  = 32'h0000_0000;
    rd_resp = `WDG_RESP_OKAY;
    case (s_axi_araddr[9:2])
      `WDG_CTRL_ADDR:     rd_val = {24'h000000, ctrl_val};
      `WDG_IRQ_STAT_ADDR: rd_val = {30'h00000000, irq_stat};
      `WDG_IRQ_MASK_ADDR: rd_val = {30'h00000000, irq_mask};
      `WDG_ENV_ADDR:      rd_val = {24'h000000, global_irq_enable, 2'h0, dog_irq_enable, 4'h0};
      `WDG_TA_ADDR:       rd_val = {30'h00000000, ta_state};
      default:            rd_resp = `WDG_RESP_SLVERR;
    endcase
  end

  // read data only follows the address handshake, never precedes it
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WDG_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_resp;
      end else if (s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // wdg_timer
